// ===== hw/coefficient_msb_sign_words.sv
// bit-16 extension and sign words of the calibration coefficients
`timescale 1ns/1ps
`include "coef_msb_sign_defs.svh"

module coefficient_msb_sign_words (
  // clock and reset
  input  wire logic                                            clk,
  input  wire logic                                            rst,
  // word writes from store load or serial commands
  input  wire coef_msb_sign_pkg::word_write_type               wordWrite,
  // word readback
  input  wire coef_msb_sign_pkg::word_read_type                readReq,
  output logic [`CMS_WORD_WIDTH-1:0]                           readData,
  output logic                                                 readValid,
  // low words of each coefficient, in slot order
  input  wire logic [`CMS_COEF_COUNT-1:0][`CMS_WORD_WIDTH-1:0] lowWords,
  // coefficients to the correction datapath
  output coef_msb_sign_pkg::coef_type [`CMS_COEF_COUNT-1:0]    coefs,
  output logic                                                 curveShapeSelect,
  output logic                                                 settleTermNegative,
  output logic                                                 wordsLoaded
);

  // decoded write strobes
  logic                           writeHigh;
  logic                           writeTemp;

  // stored words and the masked 04h image
  logic [`CMS_WORD_WIDTH-1:0]     highSigns_q;
  logic [`CMS_WORD_WIDTH-1:0]     tempHigh_q;
  logic [`CMS_WORD_WIDTH-1:0]     tempKept;
  logic [`CMS_EXT_WIDTH-1:0]      extFields;

  // load flags
  logic                           highWritten_q;
  logic                           tempWritten_q;
  logic                           wordsLoaded_q;

  // readback
  logic [`CMS_WORD_WIDTH-1:0]     readData_d;
  logic [`CMS_WORD_WIDTH-1:0]     readData_q;
  logic                           readValid_q;

  // curve shape and settling sign
  logic                           curve_q;
  logic                           settle_q;

  // one address compare each, shared by the stored word and its load flag
  assign writeHigh = wordWrite.valid && (wordWrite.addr == `CMS_ADDR_HIGH_SIGNS);
  assign writeTemp = wordWrite.valid && (wordWrite.addr == `CMS_ADDR_TEMP_HIGH);

  // word 03h: all sixteen bits carry a function, nothing is masked
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      highSigns_q <= `CMS_WORD_RESET;
    end
    else if (writeHigh)
    begin
      highSigns_q <= wordWrite.data;
    end
  end

  // 04h bits 15..6 are dropped before the flop, so they always read back zero
  assign tempKept = {{(`CMS_WORD_WIDTH-`CMS_TEMP_USED_BITS){1'b0}},
                     wordWrite.data[`CMS_TEMP_USED_BITS-1:0]};

  // word 04h
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tempHigh_q <= `CMS_WORD_RESET;
    end
    else if (writeTemp)
    begin
      tempHigh_q <= tempKept;
    end
  end

  // load flags only ever set; a reload of the same word leaves them high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      highWritten_q <= 1'b0;
    end
    else if (writeHigh)
    begin
      highWritten_q <= 1'b1;
    end
  end

  // second load flag, same behaviour for word 04h
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tempWritten_q <= 1'b0;
    end
    else if (writeTemp)
    begin
      tempWritten_q <= 1'b1;
    end
  end

  // one more flop so the flag leaves the block straight from a register;
  // it therefore rises one cycle after the second of the two words lands
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wordsLoaded_q <= 1'b0;
    end
    else
    begin
      wordsLoaded_q <= highWritten_q & tempWritten_q;
    end
  end

  // field pairs of both words in one vector; slot i sits at bits 2i and 2i+1,
  // so both words share one slot loop
  assign extFields = {tempHigh_q[`CMS_TEMP_USED_BITS-1:0],
                      highSigns_q[`CMS_HIGH_USED_BITS-1:0]};

  // every slot is built the same way: bit 16 above its low word, then sign;
  // a set sign with zero magnitude yields zero with the negative flag still up
  for (genvar i = 0; i < `CMS_COEF_COUNT; i++)
  begin : gen_coef
    localparam int MagPos  = `CMS_FIELD_STRIDE*i+`CMS_FIELD_MAG;
    localparam int SignPos = `CMS_FIELD_STRIDE*i+`CMS_FIELD_SIGN;

    logic [`CMS_MAG_WIDTH-1:0]   mag;
    logic                        neg;
    logic [`CMS_VALUE_WIDTH-1:0] unsignedValue;
    logic [`CMS_VALUE_WIDTH-1:0] negatedValue;
    logic [`CMS_VALUE_WIDTH-1:0] signedValue;
    logic                        magHigh_q;
    logic [`CMS_WORD_WIDTH-1:0]  magLow_q;
    logic                        neg_q;
    logic [`CMS_VALUE_WIDTH-1:0] value_q;

    assign mag = {extFields[MagPos], lowWords[i]};
    assign neg = extFields[SignPos];
    assign unsignedValue = {1'b0, mag};
    // eighteen bits so the largest magnitude still negates without overflow
    assign negatedValue = (`CMS_VALUE_WIDTH)'(~unsignedValue + 1'b1);
    assign signedValue = neg ? negatedValue : unsignedValue;

    // bit 16 from the stored word
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        magHigh_q <= 1'b0;
      end
      else
      begin
        magHigh_q <= mag[`CMS_MAG_WIDTH-1];
      end
    end

    // low word follows its input with one cycle of delay
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        magLow_q <= '0;
      end
      else
      begin
        magLow_q <= mag[`CMS_WORD_WIDTH-1:0];
      end
    end

    // sign
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        neg_q <= 1'b0;
      end
      else
      begin
        neg_q <= neg;
      end
    end

    // signed value
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        value_q <= '0;
      end
      else
      begin
        value_q <= signedValue;
      end
    end

    assign coefs[i] = '{negative:  neg_q,
                        magnitude: {magHigh_q, magLow_q},
                        value:     value_q};
  end

  // curve shape
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      curve_q <= 1'b0;
    end
    else
    begin
      curve_q <= highSigns_q[`CMS_CURVE_BIT];
    end
  end

  // settling sign
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      settle_q <= 1'b0;
    end
    else
    begin
      settle_q <= highSigns_q[`CMS_SETTLE_BIT];
    end
  end

  // readback decode; unmapped words answer zero rather than hold off the reader
  always_comb
  begin
    readData_d = `CMS_WORD_RESET;
    case (readReq.addr)
      `CMS_ADDR_HIGH_SIGNS:
      begin
        readData_d = highSigns_q;
      end
      `CMS_ADDR_TEMP_HIGH:
      begin
        readData_d = tempHigh_q;
      end
      default:
      begin
        readData_d = `CMS_WORD_RESET;
      end
    endcase
  end

  // one pulse per request, never stretched
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      readValid_q <= 1'b0;
    end
    else
    begin
      readValid_q <= readReq.valid;
    end
  end

  // read data holds until the next request;
  // a write in the same cycle is not yet visible to it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      readData_q <= `CMS_WORD_RESET;
    end
    else if (readReq.valid)
    begin
      readData_q <= readData_d;
    end
  end

  // outputs, all straight from flops
  assign readData           = readData_q;
  assign readValid          = readValid_q;
  assign curveShapeSelect   = curve_q;
  assign settleTermNegative = settle_q;
  assign wordsLoaded        = wordsLoaded_q;

endmodule

// ===== hw/coef_msb_sign_defs.svh
// named constants for the coefficient bit-16 and sign words
`ifndef COEF_MSB_SIGN_DEFS_SVH
`define COEF_MSB_SIGN_DEFS_SVH

`define CMS_ADDR_WIDTH      8
`define CMS_WORD_WIDTH      16
`define CMS_ADDR_HIGH_SIGNS 8'h03
`define CMS_ADDR_TEMP_HIGH  8'h04
`define CMS_WORD_RESET      16'h0000
`define CMS_HIGH_USED_BITS  14
`define CMS_TEMP_USED_BITS  6
`define CMS_CURVE_BIT       14
`define CMS_SETTLE_BIT      15
`define CMS_COEF_COUNT      10
`define CMS_MAG_WIDTH       17
`define CMS_VALUE_WIDTH     18
`define CMS_EXT_WIDTH       20
`define CMS_FIELD_MAG       0
`define CMS_FIELD_SIGN      1
`define CMS_FIELD_STRIDE    2

`endif

// ===== hw/coef_msb_sign_pkg.sv
// types shared by the coefficient bit-16 and sign words
package coef_msb_sign_pkg;

  // coefficient slots, in the order of their field pairs
  typedef enum logic [3:0] {
    COEF_BRIDGE_OFFSET         = 4'h0,
    COEF_BRIDGE_GAIN           = 4'h1,
    COEF_TEMP_GAIN_FIRST       = 4'h2,
    COEF_TEMP_OFFSET_FIRST     = 4'h3,
    COEF_SECOND_ORDER_OFFSET   = 4'h4,
    COEF_SECOND_ORDER_GAIN     = 4'h5,
    COEF_SECOND_ORDER_BRIDGE   = 4'h6,
    COEF_SENSOR_GAIN           = 4'h7,
    COEF_SENSOR_SECOND_ORDER   = 4'h8,
    COEF_SENSOR_OFFSET         = 4'h9
  } coef_index_type;

  // word write from the calibration store load or serial command path
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] data;
  } word_write_type;

  // word read request
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } word_read_type;

  // one coefficient as the correction datapath sees it
  typedef struct packed {
    logic        negative;
    logic [16:0] magnitude;
    logic [17:0] value;
  } coef_type;

endpackage

// ===== testbench/coefficient_msb_sign_words_checker.sv
// assertions on the coefficient bit-16 and sign words
`timescale 1ns/1ps
module coefficient_msb_sign_words_checker (
  // clock and reset
  input wire logic                                    clk,
  input wire logic                                    rst,
  // watched ports
  input wire coef_msb_sign_pkg::word_write_type       wordWrite,
  input wire coef_msb_sign_pkg::word_read_type        readReq,
  input wire logic [15:0]                             readData,
  input wire logic                                    readValid,
  input wire logic [9:0][15:0]                        lowWords,
  input wire coef_msb_sign_pkg::coef_type [9:0]       coefs,
  input wire logic                                    curveShapeSelect,
  input wire logic                                    settleTermNegative,
  input wire logic                                    wordsLoaded
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [19:0] ext;
  sequence s_wr03;
    wordWrite.valid && wordWrite.addr == 8'h03;
  endsequence
  sequence s_wr04;
    wordWrite.valid && wordWrite.addr == 8'h04;
  endsequence
  for (genvar i = 0; i < 10; i++)
  begin : g_slot
    assign ext[2*i] = coefs[i].magnitude[16];
    assign ext[2*i+1] = coefs[i].negative;
    a_low_join: assert property (!$past(rst) |-> coefs[i].magnitude[15:0] == $past(lowWords[i]))
      else $error("low word not joined");
    a_value_sign: assert property (coefs[i].value == (coefs[i].negative ?
      18'h0 - {1'b0, coefs[i].magnitude} : {1'b0, coefs[i].magnitude})) else $error("signed value wrong");
  end
  a_high_word_map: assert property (s_wr03 |=> ##1 ext[13:0] == $past(wordWrite.data[13:0], 2))
    else $error("word 03h fields wrong");
  a_curve_select: assert property (s_wr03 |=> ##1 curveShapeSelect == $past(wordWrite.data[14], 2))
    else $error("curve select wrong");
  a_settle_sign: assert property (s_wr03 |=> ##1 settleTermNegative == $past(wordWrite.data[15], 2))
    else $error("settle sign wrong");
  a_temp_word_map: assert property (s_wr04 |=> ##1 ext[19:14] == $past(wordWrite.data[5:0], 2))
    else $error("word 04h fields wrong");
  a_reset_zero: assert property ($past(rst) |-> ext == 20'h0 && !curveShapeSelect && !settleTermNegative)
    else $error("fields not zero after reset");
  a_temp_unused: assert property (readReq.valid && readReq.addr == 8'h04 |=> readValid && readData[15:6] == 10'h0)
    else $error("word 04h upper bits not ignored");
  a_loaded_reset: assert property ($past(rst) |-> !wordsLoaded)
    else $error("load flag set after reset");
endmodule
bind coefficient_msb_sign_words coefficient_msb_sign_words_checker coefficient_msb_sign_words_checker_i (
  .clk(clk), .rst(rst), .wordWrite(wordWrite), .readReq(readReq), .readData(readData), .readValid(readValid),
  .lowWords(lowWords), .coefs(coefs), .curveShapeSelect(curveShapeSelect),
  .settleTermNegative(settleTermNegative), .wordsLoaded(wordsLoaded));

// ===== testbench/tb_coefficient_msb_sign_words.sv
// self-checking bench for the coefficient bit-16 and sign words
`timescale 1ns/1ps
module tb_coefficient_msb_sign_words;
  logic                                clk = 1'b0;
  logic                                rst = 1'b1;
  coef_msb_sign_pkg::word_write_type   wordWrite = '0;
  coef_msb_sign_pkg::word_read_type    readReq = '0;
  logic [9:0][15:0]                    lowWords = '0;
  logic [15:0]                         readData;
  logic                                readValid;
  coef_msb_sign_pkg::coef_type [9:0]   coefs;
  logic                                curveShapeSelect;
  logic                                settleTermNegative;
  logic                                wordsLoaded;
  logic [15:0]                         expQ[$];
  logic [15:0]                         img[2];
  int                                  badCount = 0;
  int                                  nTests = 0;
  int                                  seed = 45561;
  always #5 clk = ~clk;
  coefficient_msb_sign_words coefficient_msb_sign_words_i (.clk(clk), .rst(rst), .wordWrite(wordWrite),
    .readReq(readReq), .readData(readData), .readValid(readValid), .lowWords(lowWords), .coefs(coefs),
    .curveShapeSelect(curveShapeSelect), .settleTermNegative(settleTermNegative), .wordsLoaded(wordsLoaded));
  // a read in the write's cycle must see the old word
  task automatic cyc(input logic wv, input logic [7:0] wa, input logic [15:0] wd, input logic rv,
                     input logic [7:0] ra);
    @(posedge clk);
    wordWrite <= {wv, wa, wd};
    readReq <= {rv, ra};
    for (int i = 0; i < 10; i++) lowWords[i] <= 16'($random(seed));
    if (rv) expQ.push_back(ra == 8'h03 ? img[0] : ra == 8'h04 ? img[1] : 16'h0000);
    if (wv && wa == 8'h03) img[0] = wd;
    if (wv && wa == 8'h04) img[1] = wd & 16'h003f;
  endtask
  task automatic chk(input logic [15:0] got);
    logic [15:0] exp;
    exp = expQ.size() ? expQ.pop_front() : 16'hxxxx;
    nTests++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      badCount++;
    end
  endtask
  task automatic chkFlags(input logic [2:0] got, input logic [2:0] exp);
    nTests++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      badCount++;
    end
  endtask
  task automatic endSim();
    if (badCount == 0 && nTests > 0 && expQ.size() == 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge clk) if (readValid === 1'b1) chk(readData);
  initial
  begin
    #20000;
    badCount++;
    endSim();
  end
  initial
  begin
    img = '{16'h0, 16'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2)
    begin
      @(negedge clk);
      chkFlags({wordsLoaded, curveShapeSelect, settleTermNegative}, 3'h0);
      cyc(0, 8'h00, 16'h0, 1, 8'h03);
      cyc(0, 8'h00, 16'h0, 1, 8'h04);
      cyc(1, 8'h03, 16'hffff, 1, 8'h03);
      cyc(1, 8'h04, 16'hffff, 1, 8'h03);
      cyc(1, 8'h05, 16'h1234, 1, 8'h04);
      cyc(0, 8'h00, 16'h0, 1, 8'h05);
      repeat (200) cyc(1'($random(seed)), 8'h02 + 8'($random(seed) & 3), 16'($random(seed)),
                       1'($random(seed)), 8'h02 + 8'($random(seed) & 3));
      cyc(0, 8'h00, 16'h0, 0, 8'h00);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chkFlags({wordsLoaded, curveShapeSelect, settleTermNegative}, {1'b1, img[0][14], img[0][15]});
      @(posedge clk);
      // second reset in mid-run brings the fields back to zero
      rst <= 1'b1;
      img = '{16'h0, 16'h0};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
    end
    repeat (3) @(posedge clk);
    endSim();
  end
endmodule
